// File: capacitive_pad_scan_threshold_bench.sv
// capacitive_pad_scan_threshold_bench.sv: self-checking bench for cpst_top
// assumes the oscillator model on the pad side and a free-running low-speed clock
`timescale 1ns/100ps
`include "cpst_map.vh"
module capacitive_pad_scan_threshold_bench;
    logic        core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, v;
    logic [4:0]  lc = 5'h00;
    wire  [31:0] prdata;
    wire  [15:0] ref_cap_value;
    wire  [3:0]  pad_osc_in, pad_osc_on, touch_pad_mode;
    wire         pready, pslverr, ref_osc_in, ref_osc_on, busy, ovf, thr;
    logic [32:0] exp_q[$];
    string       nm_q[$];
    int          error_cnt = 0, checked = 0, ovf_cnt = 0, thr_cnt = 0, i;
    logic        tss_t [4] = '{1, 1, 0, 0};
    logic        dir_t [4] = '{1, 0, 1, 0};
    logic        hit_t [4] = '{1, 0, 0, 1};
    logic [15:0] thr_t [4] = '{16'h0001, 16'h0001, 16'hFFFF, 16'hFFFF};
    always #2 core_clk = ~core_clk;
    // low-speed clock runs free, far slower than core_clk
    always @(posedge core_clk) lc <= lc + 5'h01;
    always @(posedge core_clk) ovf_cnt <= ovf_cnt + ovf;
    always @(posedge core_clk) thr_cnt <= thr_cnt + thr;
    cpst_top dut_u (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .pad_osc_in(pad_osc_in), .ref_osc_in(ref_osc_in), .lirc_in(lc[4]), .pad_osc_on(pad_osc_on),
        .ref_osc_on(ref_osc_on), .touch_pad_mode(touch_pad_mode), .ref_cap_value(ref_cap_value),
        .scan_in_progress(busy), .slot_overflow_event(ovf), .threshold_event(thr));
    cpst_pad_model pad_u (.core_clk(core_clk), .rst(rst), .pad_osc_on(pad_osc_on),
        .ref_osc_on(ref_osc_on), .pad_osc_in(pad_osc_in), .ref_osc_in(ref_osc_in));
    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    always @(posedge core_clk)
        if (psel && penable && pready && !pwrite && exp_q.size() > 0)
            chk(nm_q.pop_front(), exp_q.pop_front(), {pslverr, prdata});
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        // only the watchdog ends a stuck wait
        while (pready !== 1'b1)
            @(posedge core_clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        nm_q.push_back($sformatf("read %h", a));
        apb(1'b0, a, 32'h0);
    endtask
    task scan(input logic [31:0] tc0, input logic hit);
        int n0, t0, n;
        n0 = ovf_cnt;
        t0 = thr_cnt;
        n = 0;
        apb(1'b1, `CPST_OFS_TC0, tc0);
        while (ovf_cnt == n0 && n < 3000)
        begin
            @(posedge core_clk);
            n++;
        end
        repeat (4) @(posedge core_clk);
        chk("slot_overflow_event", 33'h1, ovf_cnt - n0);
        chk("threshold_event", hit, thr_cnt - t0);
    endtask
    task end_of_test;
        if (error_cnt == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        #200000;
        error_cnt++;
        end_of_test;
    end
    initial
    begin
        v = $urandom(32'h5cb0);
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        for (i = 0; i < 9; i++) rd(4 * i, (i == 1) ? 33'h0E4 : 33'h0);
        rd(12'h0FC, 33'h1_0000_0000);
        v = $urandom;
        apb(1'b1, `CPST_OFS_SLOT, {24'h0, v[7:0]});
        rd(`CPST_OFS_SLOT, {25'h0, v[7:0]});
        for (i = 0; i < 4; i++)
        begin
            apb(1'b1, `CPST_OFS_MC1, {24'h0, tss_t[i], 7'h31});
            apb(1'b1, `CPST_OFS_SLOT, 32'hFE);
            apb(1'b1, `CPST_OFS_THR, {16'h0, thr_t[i]});
            apb(1'b1, `CPST_OFS_THS, {31'h0, dir_t[i]});
            apb(1'b1, `CPST_OFS_TC0, 32'h10);
            rd(`CPST_OFS_CNT, 33'h0);
            scan(32'h11, hit_t[i]);
            rd(`CPST_OFS_SLOT, 33'hFE);
            rd(`CPST_OFS_THS, {28'h0, hit_t[i], 3'h0, dir_t[i]});
            apb(1'b1, `CPST_OFS_THS, {31'h0, dir_t[i]});
            rd(`CPST_OFS_THS, {32'h0, dir_t[i]});
        end
        // auto modes 00, 10, 11; the last one walks all four slots, but only slot 0 has an enabled pad to scan
        for (i = 0; i < 4; i++)
        begin
            if (i == 1)
                continue;
            v = $urandom;
            apb(1'b1, 12'h050, {16'h0, v[15:0]});
            apb(1'b1, 12'h060, 32'h1);
            apb(1'b1, `CPST_OFS_MC1, 32'h81);
            apb(1'b1, `CPST_OFS_TC2, {31'h0, i != 3});
            apb(1'b1, `CPST_OFS_THS, 32'h1);
            apb(1'b1, `CPST_OFS_TC0, {26'h0, i[1:0], 4'h0});
            scan({26'h0, i[1:0], 4'h1}, 1'b1);
            if (i != 3)
                chk("ref_cap_value", {17'h0, v[15:0]}, ref_cap_value);
            rd(`CPST_OFS_MC1, 33'h81);
            rd(`CPST_OFS_THS, 33'h11);
        end
        end_of_test;
    end
endmodule // capacitive_pad_scan_threshold_bench

// File: cpst_edge_cnt.v
// cpst_edge_cnt.v: counts rising edges of a slow oscillator sampled on core_clk
// assumes sig is synchronous to core_clk and far slower than it
`timescale 1ns/100ps
module cpst_edge_cnt #(
    parameter W = 16
) (
    input  wire         core_clk,
    input  wire         rst,
    input  wire         clr,
    input  wire         en,
    input  wire         sig,
    output reg  [W-1:0] count,
    output wire         rise
);
    reg sig_q;

    assign rise = sig & ~sig_q;

    always @(posedge core_clk)
    begin
        if (rst)
            sig_q <= 1'b0;
        else
            sig_q <= sig;
    end

    // wraps silently; a window long enough to wrap is a setup error
    always @(posedge core_clk)
    begin
        if (rst || clr)
            count <= {W{1'b0}};
        else if (en && rise)
            count <= count + 1'b1;
    end
endmodule // cpst_edge_cnt

// File: cpst_map.vh
// cpst_map.vh: register offsets, field positions, reset values and codes of the pad scanner
// assumes a 12-bit APB byte address, one 32-bit word per register
`ifndef CPST_MAP_VH
`define CPST_MAP_VH

`define CPST_OFS_MC1      12'h000
`define CPST_OFS_MC2      12'h004
`define CPST_OFS_TC0      12'h008
`define CPST_OFS_TC2      12'h00C
`define CPST_OFS_SLOT     12'h010
`define CPST_OFS_THR      12'h014
`define CPST_OFS_CNT      12'h018
`define CPST_OFS_REF      12'h01C
`define CPST_OFS_THS      12'h020
`define CPST_MEM_BASE     6'h01

`define CPST_MC1_TSS      7
`define CPST_MC1_ROEN     5
`define CPST_MC1_KOEN     4
`define CPST_TC0_START    0
`define CPST_TC0_MODE_LO  4
`define CPST_TC0_MODE_HI  5
`define CPST_TC0_BUSY     7

`define CPST_RST_MC1      8'h00
`define CPST_RST_MC2      8'hE4
`define CPST_RST_TC0      8'h00
`define CPST_RST_TC2      8'h00
`define CPST_RST_SLOT     8'h00
`define CPST_RST_THS      8'h00

`define CPST_MODE_AUTO    2'b00
`define CPST_MODE_MANUAL  2'b01

`define CPST_REG_CNT      2'b00
`define CPST_REG_REF      2'b01
`define CPST_REG_THR      2'b10

`define CPST_UNIT_MAX     5'h1F
`define CPST_SLOT_MAX     8'hFF

`endif

// File: cpst_pad_cmp.v
// cpst_pad_cmp.v: one pad's threshold comparator
// assumes check is a one-cycle strobe at the end of that pad's slot
`timescale 1ns/100ps
module cpst_pad_cmp #(
    parameter W = 16
) (
    input  wire [W-1:0] count,
    input  wire [W-1:0] threshold,
    input  wire         upper_sel,
    input  wire         check,
    output wire         hit
);
    assign hit = check & (upper_sel ? (count > threshold) : (count < threshold));
endmodule // cpst_pad_cmp

// File: cpst_pad_model.sv
// cpst_pad_model.sv: behavioural sense and reference oscillators
// assumes the *_on enables come from cpst_top on core_clk
`timescale 1ns/100ps
module cpst_pad_model (
    input  wire        core_clk,
    input  wire        rst,
    input  wire [3:0]  pad_osc_on,
    input  wire        ref_osc_on,
    output logic [3:0] pad_osc_in,
    output logic       ref_osc_in
);
    logic [3:0] cnt_r [0:4];
    logic [4:0] osc_r;
    wire  [4:0] on_w = {ref_osc_on, pad_osc_on};
    assign {ref_osc_in, pad_osc_in} = osc_r;
    // half period i+2 cycles, each one independent; stopped lines rest at 0
    always @(posedge core_clk)
    begin
        for (int i = 0; i < 5; i++)
        begin
            if (rst || !on_w[i])
            begin
                cnt_r[i] <= 4'h0;
                osc_r[i] <= 1'b0;
            end
            else if (cnt_r[i] == i + 1)
            begin
                cnt_r[i] <= 4'h0;
                osc_r[i] <= ~osc_r[i];
            end
            else
                cnt_r[i] <= cnt_r[i] + 4'h1;
        end
    end
endmodule // cpst_pad_model

// File: cpst_top.v
// cpst_top.v: four-pad capacitive scanner with APB registers and scan sequencer
// assumes oscillator inputs are synchronous to core_clk; pin analog is outside
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "cpst_map.vh"

// What this block does
// - pad flag goes 1 on threshold crossing, else stays 0
// - direction bit 0 compares lower threshold, 1 compares upper
// - at scan end compare count with threshold, set flag, pulse threshold event
// - four pad inputs, each with own oscillator, touch/GPIO function selectable
// - count sense oscillator cycles during the reference window
// - start bit low clears cycle counter, 16-bit counter, 5-bit unit counter
// - start bit low leaves the 8-bit slot counter preset untouched
// - start bit rising starts all four scan counters
// - slot overflow stops both oscillators and all scan counters
// - slot counter clocked from reference oscillator or low-speed clock
// - manual mode pulses slot overflow event at window end
// - auto scan skips disabled pads; the overflow event needs at least one enabled pad
// - mode field 00 selects auto scan
// - mode field 10 and 11 both select auto scan, one pass as with 00
// - auto scan walks pads given by four per-slot select fields
// - slot count config bit sets number of auto scan slots
// - config 0 runs slots 0 to 3, config 1 only slot 0
// - auto scan loads reference capacitor pair from data memory
// - auto scan stores cycle count pair into data memory
module cpst_top (
    input  wire        core_clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output reg         pslverr,
    input  wire [3:0]  pad_osc_in,
    input  wire        ref_osc_in,
    input  wire        lirc_in,
    output wire [3:0]  pad_osc_on,
    output wire        ref_osc_on,
    output wire [3:0]  touch_pad_mode,
    output wire [15:0] ref_cap_value,
    output wire        scan_in_progress,
    output reg         slot_overflow_event,
    output reg         threshold_event
);
    localparam ST_IDLE  = 2'd0;
    localparam ST_LOAD  = 2'd1;
    localparam ST_SCAN  = 2'd2;
    localparam ST_STORE = 2'd3;

    reg  [7:0]  mc1_r;
    reg  [7:0]  mc2_r;
    reg  [7:0]  tc0_r;
    reg  [7:0]  tc2_r;
    reg  [7:0]  slot_preset_r;
    reg  [15:0] thr_r;
    reg  [15:0] ref_r;
    reg  [7:0]  ths_r;
    reg  [15:0] mem_r [0:11];
    reg  [1:0]  state_r;
    reg  [1:0]  slot_r;
    reg  [4:0]  unit_r;
    reg  [7:0]  slot_cnt_r;
    reg         start_q;
    reg         lirc_q;
    reg         ran_r;

    wire        wr_en    = psel & penable & pwrite;
    wire        setup    = psel & ~penable;
    wire        start    = tc0_r[`CPST_TC0_START];
    wire        start_up = start & ~start_q;
    wire [1:0]  mode     = tc0_r[`CPST_TC0_MODE_HI:`CPST_TC0_MODE_LO];
    wire        periodic = mode[1];
    wire        manual   = ~periodic & mode[0];
    wire        use_lirc = mc1_r[`CPST_MC1_TSS];
    wire [3:0]  key_en   = mc1_r[3:0];
    wire        scan_on  = (state_r == ST_SCAN);
    wire        busy     = (state_r != ST_IDLE);
    wire [1:0]  cur_pad  = manual ? mc2_r[1:0] : mc2_r[2*slot_r +: 2];
    wire [1:0]  last_slot = tc2_r[0] ? 2'd0 : 2'd3;
    wire        pad_ok   = key_en[cur_pad];
    // count restarts per scanned slot so each pad gets its own figure
    wire        cnt_clr  = ~start | ((state_r == ST_LOAD) & pad_ok);
    wire [15:0] cycle_cnt;
    wire        ref_rise;
    wire        lirc_rise = lirc_in & ~lirc_q;
    wire        slot_tick = use_lirc ? lirc_rise : ref_rise;
    wire        unit_wrap = use_lirc | (unit_r == `CPST_UNIT_MAX);
    wire        slot_ovf  = scan_on & slot_tick & unit_wrap & (slot_cnt_r == `CPST_SLOT_MAX);
    wire        check     = (state_r == ST_STORE);
    wire [3:0]  hit;
    wire        at_last   = manual | (slot_r == last_slot);
    // every exit to idle, so the oscillator enables drop whenever busy falls
    wire        scan_done = check ? at_last : ((state_r == ST_LOAD) ? (~pad_ok & at_last) : (scan_on & ~start));
    wire [3:0]  mem_idx   = {paddr[5:4], paddr[3:2]};
    wire        mem_hit   = (paddr[11:6] == `CPST_MEM_BASE) && (paddr[5:4] != 2'b11);
    wire [3:0]  cnt_idx   = {`CPST_REG_CNT, cur_pad};
    wire [3:0]  ref_idx   = {`CPST_REG_REF, cur_pad};
    wire [3:0]  thr_idx   = {`CPST_REG_THR, cur_pad};

    assign pready           = psel & penable;
    assign scan_in_progress = busy;
    assign ref_cap_value    = ref_r;
    assign touch_pad_mode   = key_en;
    // oscillators run only inside a slot; the overflow ends the slot and so stops them
    assign ref_osc_on = mc1_r[`CPST_MC1_ROEN] & scan_on;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_pad
            assign pad_osc_on[gi] = mc1_r[`CPST_MC1_KOEN] & key_en[gi] & scan_on & (cur_pad == gi);
            cpst_pad_cmp #(.W(16)) u_cmp (
                .count     (cycle_cnt),
                .threshold (thr_r),
                .upper_sel (ths_r[gi]),
                .check     (check & (cur_pad == gi)),
                .hit       (hit[gi])
            );
        end
    endgenerate

    // sense cycles of the selected pad during the window
    cpst_edge_cnt #(.W(16)) u_cycle (
        .core_clk (core_clk),
        .rst      (rst),
        .clr      (cnt_clr),
        .en       (scan_on & pad_ok),
        .sig      (pad_osc_in[cur_pad]),
        .count    (cycle_cnt),
        .rise     ()
    );

    // reference cycles; its edge also times the slot unless the low-speed clock is selected
    cpst_edge_cnt #(.W(16)) u_refcnt (
        .core_clk (core_clk),
        .rst      (rst),
        .clr      (cnt_clr),
        .en       (scan_on),
        .sig      (ref_osc_in),
        .count    (),
        .rise     (ref_rise)
    );

    always @(posedge core_clk)
    begin
        if (rst)
        begin
            start_q <= 1'b0;
            lirc_q  <= 1'b0;
        end
        else
        begin
            start_q <= start;
            lirc_q  <= lirc_in;
        end
    end

    // window timing: 5-bit unit prescale on reference edges (none on the low-speed clock), then the 8-bit slot counter up to overflow
    always @(posedge core_clk)
    begin
        if (rst || cnt_clr)
            unit_r <= 5'h00;
        else if (start_up || state_r == ST_LOAD)
            unit_r <= 5'h00;
        else if (scan_on && slot_tick && !use_lirc)
            unit_r <= unit_r + 1'b1;
    end

    // the preset is never touched here, only the running copy
    always @(posedge core_clk)
    begin
        if (rst)
            slot_cnt_r <= `CPST_RST_SLOT;
        else if (start_up || state_r == ST_LOAD)
            slot_cnt_r <= slot_preset_r;
        else if (scan_on && slot_tick && unit_wrap)
            slot_cnt_r <= slot_cnt_r + 1'b1;
    end

    // scan sequencer
    always @(posedge core_clk)
    begin
        slot_overflow_event <= 1'b0;
        threshold_event     <= 1'b0;
        if (rst)
        begin
            state_r <= ST_IDLE;
            slot_r  <= 2'd0;
            ran_r   <= 1'b0;
        end
        else
        begin
            threshold_event <= |hit;
            case (state_r)
            ST_IDLE:
                if (start_up)
                begin
                    slot_r  <= 2'd0;
                    ran_r   <= 1'b0;
                    state_r <= manual ? ST_SCAN : ST_LOAD;
                end
            ST_LOAD:
                if (pad_ok)
                    state_r <= ST_SCAN;
                else if (slot_r == last_slot)
                begin
                    state_r             <= ST_IDLE;
                    slot_overflow_event <= ran_r;
                end
                else
                    slot_r <= slot_r + 1'b1;
            ST_SCAN:
                if (!start)
                    state_r <= ST_IDLE;
                else if (slot_ovf)
                begin
                    state_r <= ST_STORE;
                    ran_r   <= 1'b1;
                end
            default:
                if (manual || slot_r == last_slot)
                begin
                    state_r             <= ST_IDLE;
                    slot_overflow_event <= manual ? (|key_en) : 1'b1;
                end
                else
                begin
                    slot_r  <= slot_r + 1'b1;
                    state_r <= ST_LOAD;
                end
            endcase
        end
    end

    // register file; hardware updates win over a same-cycle software write
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            mc1_r         <= `CPST_RST_MC1;
            mc2_r         <= `CPST_RST_MC2;
            tc0_r         <= `CPST_RST_TC0;
            tc2_r         <= `CPST_RST_TC2;
            slot_preset_r <= `CPST_RST_SLOT;
            thr_r         <= 16'h0000;
            ref_r         <= 16'h0000;
            ths_r         <= `CPST_RST_THS;
        end
        else
        begin
            if (wr_en)
            begin
                if (paddr == `CPST_OFS_MC1)
                    mc1_r <= {pwdata[7], 1'b0, pwdata[5:0]};
                else if (paddr == `CPST_OFS_MC2)
                    mc2_r <= pwdata[7:0];
                else if (paddr == `CPST_OFS_TC0)
                    tc0_r <= {1'b0, 1'b0, pwdata[5:4], 3'b000, pwdata[0]};
                else if (paddr == `CPST_OFS_TC2)
                    tc2_r <= {7'h00, pwdata[0]};
                else if (paddr == `CPST_OFS_SLOT)
                    slot_preset_r <= pwdata[7:0];
                else if (paddr == `CPST_OFS_THR)
                    thr_r <= pwdata[15:0];
                else if (paddr == `CPST_OFS_REF)
                    ref_r <= pwdata[15:0];
                else if (paddr == `CPST_OFS_THS)
                    ths_r <= pwdata[7:0];
            end
            if (!manual && start_up)
                mc1_r[`CPST_MC1_ROEN:`CPST_MC1_KOEN] <= {~use_lirc, 1'b1};
            if (scan_done)
            begin
                mc1_r[`CPST_MC1_ROEN] <= 1'b0;
                mc1_r[`CPST_MC1_KOEN] <= 1'b0;
            end
            if (state_r == ST_LOAD && pad_ok)
            begin
                ref_r <= mem_r[ref_idx];
                thr_r <= mem_r[thr_idx];
            end
            // flag set beats a clearing write in the same cycle
            ths_r[7:4] <= (wr_en && paddr == `CPST_OFS_THS ? pwdata[7:4] : ths_r[7:4]) | hit;
        end
    end

    // touch data memory: counts, reference caps, thresholds per pad
    integer mi;
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            for (mi = 0; mi < 12; mi = mi + 1)
                mem_r[mi] <= 16'h0000;
        end
        else if (check && !manual)
            mem_r[cnt_idx] <= cycle_cnt;
        else if (wr_en && mem_hit)
            mem_r[mem_idx] <= pwdata[15:0];
    end

    // read data captured in the setup cycle, so it is stable through the access
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            if (paddr == `CPST_OFS_MC1)
                prdata[7:0] <= mc1_r;
            else if (paddr == `CPST_OFS_MC2)
                prdata[7:0] <= mc2_r;
            else if (paddr == `CPST_OFS_TC0)
                prdata[7:0] <= {busy, tc0_r[6:0]};
            else if (paddr == `CPST_OFS_TC2)
                prdata[7:0] <= tc2_r;
            else if (paddr == `CPST_OFS_SLOT)
                prdata[7:0] <= slot_preset_r;
            else if (paddr == `CPST_OFS_THR)
                prdata[15:0] <= thr_r;
            else if (paddr == `CPST_OFS_CNT)
                prdata[15:0] <= cycle_cnt;
            else if (paddr == `CPST_OFS_REF)
                prdata[15:0] <= ref_r;
            else if (paddr == `CPST_OFS_THS)
                prdata[7:0] <= ths_r;
            else if (mem_hit)
                prdata[15:0] <= mem_r[mem_idx];
            else
                pslverr <= 1'b1;
        end
    end
endmodule // cpst_top

// File: cpst_top_checker.sv
// cpst_top_checker.sv: port-level assertions for the pad scanner
// assumes a bind onto cpst_top, one core_clk domain
`timescale 1ns/100ps
module cpst_checker (
    input wire       core_clk,
    input wire       rst,
    input wire [3:0] pad_osc_on,
    input wire       ref_osc_on,
    input wire [3:0] touch_pad_mode,
    input wire       scan_in_progress,
    input wire       slot_overflow_event,
    input wire       threshold_event
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_ovf_needs_pad: assert property (slot_overflow_event |-> |touch_pad_mode)
        else $error("overflow event with no pad enabled");
    a_ovf_one_pulse: assert property (slot_overflow_event |=> !slot_overflow_event)
        else $error("overflow event longer than one cycle");
    a_thr_one_pulse: assert property (threshold_event |=> !threshold_event)
        else $error("threshold event longer than one cycle");
    a_osc_idle_off: assert property (!scan_in_progress |-> (pad_osc_on == 4'h0) && !ref_osc_on)
        else $error("oscillator on while idle");
    a_one_pad_osc: assert property ($onehot0(pad_osc_on))
        else $error("two pad oscillators on");
    a_osc_pad_enabled: assert property ((pad_osc_on & ~touch_pad_mode) == 4'h0)
        else $error("disabled pad oscillating");
    a_ovf_ends_busy: assert property (slot_overflow_event |-> ##[0:2] !scan_in_progress)
        else $error("scan still busy after overflow");
    a_ovf_from_scan: assert property (slot_overflow_event |-> $past(scan_in_progress))
        else $error("overflow event without a scan");
    a_thr_from_scan: assert property (threshold_event |-> $past(scan_in_progress, 2) || $past(scan_in_progress))
        else $error("threshold event without a scan");
endmodule // cpst_checker
bind cpst_top cpst_checker chk_u (
    .core_clk(core_clk), .rst(rst), .pad_osc_on(pad_osc_on), .ref_osc_on(ref_osc_on),
    .touch_pad_mode(touch_pad_mode), .scan_in_progress(scan_in_progress),
    .slot_overflow_event(slot_overflow_event), .threshold_event(threshold_event));
